// >>> hdl/link_regs_defines.svh
// Purpose: constants for the link control and status register bank
// Assumes: AHB-Lite word registers, byte address is four times the index
// Notes: Operation list below
// Operation
// - five-fourths enable bit 7 selects 1.25x/2.5x rate, else 1x/2x.
// - sync select bit 6: 0 single-ended sync, 1 differential sync input.
// - test-pattern field bits 3-0 resets to 0, meaning normal data.
// - codes 1 to 9 select the nine listed lane test patterns.
// - code 10 holds lanes low, 11 high, 12-15 reserved.
// - identifier byte is sent as DID in second ILA multiframe.
// - frame char code 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - end-of-frame comma inserted opportunistically, not every frame.
// - link-active bit 6 reads 1 exactly in data-encoding state while the link is enabled.
// - sync-state bit 5 shows live selected sync level, low when asserted.
// - realigned flag bit 4 sets on sysref phase shift; write 1 clears.
// - multiframe_flag_a flag bit 3 sets on first sysref after enable; write 1 clears.
// - pll lock bit 2 reads 1 while serializer pll locked.
// - link disabled holds link in reset, serializers down, clocks gated.
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH
`define IDX_CTRL_TWO 12'h202
`define IDX_DEV_ID 12'h203
`define IDX_CTRL_THREE 12'h204
`define IDX_STATUS 12'h205
`define IDX_IRQ_MASK 12'h206
`define IDX_LINK_EN 12'h207
`define BIT_FIVE_FOURTHS 7
`define BIT_LINK_EN 0
`define IDX_HI 13
`define IDX_LO 2
`define PAT_HI 3
`define FRAME_END_CHAR_SELECT_HI 1
`define STATUS_RSVD_MASK 8'h83
`define KCODE_K28_7 8'hFC
`define KCODE_K28_1 8'h3C
`define KCODE_K28_5 8'hBC
`define BIT_SYNC_SEL 6
`define BIT_LINK_UP 6
`define BIT_SYNC_ST 5
`define BIT_REALIGNED 4
`define BIT_MULTIFRAME_FLAG_A 3
`define BIT_PLL_LOCK 2
`define CTRL_TWO_MASK 8'hCF
`define CTRL_THREE_MASK 8'h03
`define FLAG_MASK 8'h18
`define RESET_BYTE 8'h00
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2
`define PATTERN_LOW 4'hA
`define PATTERN_HIGH 4'hB
`define PATTERN_LAST_VALID 4'hB
`endif

// >>> hdl/link_regs_pkg.sv
// Purpose: types for the link register bank
// Assumes: nothing
// Notes: none
package link_regs_pkg;
    typedef enum logic [1:0] {FC_K28_7, FC_K28_1, FC_K28_5, FC_RSVD} frame_char_t;
    typedef enum logic [3:0] {
        TP_NORMAL, TP_PRBS7, TP_PRBS15, TP_PRBS23, TP_RAMP, TP_TRANSPORT,
        TP_D21_5, TP_K28_5, TP_REPEAT_ILA, TP_RPAT, TP_HOLD_LOW, TP_HOLD_HIGH,
        TP_RSVD12, TP_RSVD13, TP_RSVD14, TP_RSVD15
    } test_pattern_t;
    typedef struct packed {
        logic en_d;
        logic armed;
        logic realigned;
        logic multiframe_flag_a;
    } flag_state_t;
    typedef struct packed {
        logic [7:0] ctrl_two;
        logic [7:0] dev_id;
        logic [7:0] ctrl_three;
        logic [7:0] irq_mask;
        logic link_en;
        logic wr_pend;
        logic rd_pend;
        logic [11:0] idx;
        logic [31:0] rdata;
    } bank_state_t;
endpackage : link_regs_pkg

// >>> hdl/align_flags.sv
// Purpose: sticky sysref alignment flags
// Assumes: events are one-cycle pulses on clk_in
// Notes: set wins over a same-cycle clear
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defines.svh"
module align_flags (
    input wire logic clk_in,               // clock
    input wire logic reset_in,             // sync reset
    input wire logic link_en_in,           // link enable
    input wire logic sysref_event_in,      // sysref seen
    input wire logic phase_shift_in,       // sysref moved a clock phase
    input wire logic clr_realigned_in,     // write-1 clear
    input wire logic clr_multiframe_flag_a_in,       // write-1 clear
    output logic realigned_out,            // sticky flag
    output logic multiframe_flag_a_out               // sticky flag
);
    import link_regs_pkg::*;
    flag_state_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.en_d = link_en_in;
        if (link_en_in && !st_ff.en_d) begin
            nxt_st.armed = 1'b1;
        end
        if (!link_en_in) begin
            nxt_st.armed = 1'b0;
        end
        if (clr_realigned_in) begin
            nxt_st.realigned = 1'b0;
        end
        if (clr_multiframe_flag_a_in) begin
            nxt_st.multiframe_flag_a = 1'b0;
        end
        if (phase_shift_in) begin
            nxt_st.realigned = 1'b1;
        end
        if (st_ff.armed && sysref_event_in) begin
            nxt_st.multiframe_flag_a = 1'b1;
            nxt_st.armed = 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign realigned_out = st_ff.realigned;
    assign multiframe_flag_a_out = st_ff.multiframe_flag_a;

    property p_multiframe_flag_a_set;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.armed && sysref_event_in) |=> multiframe_flag_a_out;
    endproperty
    a_multiframe_flag_a_set: assert property (p_multiframe_flag_a_set) else $error("multiframe_flag_a not set");
    property p_realign_set;
        @(posedge clk_in) disable iff (reset_in)
        phase_shift_in |=> realigned_out;
    endproperty
    a_realign_set: assert property (p_realign_set) else $error("realigned not set");
endmodule : align_flags
`default_nettype wire

// >>> hdl/lane_pattern_ctrl.sv
// Purpose: decode link controls into lane-side selects
// Assumes: decode is combinational, settings static while link enabled
// Notes: reserved pattern codes fall back to normal data, the reserved frame char code to K28.7
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defines.svh"
module lane_pattern_ctrl (
    input wire logic [3:0] pattern_in,     // test pattern code
    input wire logic [1:0] end_char_code_in, // frame char code
    input wire logic link_en_in,           // link enable
    output logic [3:0] pattern_out,        // effective pattern
    output logic [7:0] end_char_out,       // comma K-code low byte
    output logic lanes_static_out,         // lanes held static
    output logic lanes_level_out           // static level
);
    import link_regs_pkg::*;
    always_comb begin
        pattern_out = (pattern_in > `PATTERN_LAST_VALID) ? TP_NORMAL : pattern_in;
        lanes_static_out = link_en_in &&
            (pattern_in == `PATTERN_LOW || pattern_in == `PATTERN_HIGH);
        lanes_level_out = (pattern_in == `PATTERN_HIGH);
        unique case (frame_char_t'(end_char_code_in))
            FC_K28_1: end_char_out = `KCODE_K28_1;
            FC_K28_5: end_char_out = `KCODE_K28_5;
            default: end_char_out = `KCODE_K28_7; // reserved code falls back to the default
        endcase
    end
endmodule : lane_pattern_ctrl
`default_nettype wire

// >>> hdl/link_regs.sv
// Purpose: AHB-Lite control/status bank for a serial transmit link
// Assumes: single word transfers, one-cycle wait-free slave
// Notes: link enable and irq mask live at chosen extra indices
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defines.svh"
module link_regs (
    input wire logic clk_in,               // 20 MHz clock
    input wire logic reset_in,             // sync reset, active high
    input wire logic hsel_in,              // slave select
    input wire logic [31:0] haddr_in,      // byte address
    input wire logic [1:0] htrans_in,      // transfer type
    input wire logic hwrite_in,            // write
    input wire logic [2:0] hsize_in,       // transfer size
    input wire logic hready_in,            // bus ready
    input wire logic [31:0] hwdata_in,     // write data
    output logic [31:0] hrdata_out,        // read data
    output logic hreadyout_out,            // always ready
    output logic hresp_out,                // always OKAY
    input wire logic single_ended_sync_n_in, // single-ended sync, low asserted
    input wire logic differential_sync_n_in, // differential sync, low asserted
    input wire logic data_encoding_state_in, // link in data-encoding state
    input wire logic pll_locked_in,        // serializer pll lock
    input wire logic sysref_event_in,      // sysref pulse
    input wire logic phase_shift_in,       // sysref shifted a clock phase
    input wire logic frame_end_ok_in,      // replacement conditions met
    output logic pll_five_fourths_enable_out, // 5/4 multiplier on
    output logic [3:0] link_test_pattern_select_out, // pattern code
    output logic [7:0] link_device_identifier_out, // ILA DID byte
    output logic [7:0] frame_end_char_out, // comma K-code
    output logic insert_frame_end_out,     // insert comma this frame
    output logic lanes_static_out,         // lanes held static
    output logic lanes_level_out,          // static level
    output logic link_reset_out,           // link held in reset
    output logic serializer_pd_out,        // serializers powered down
    output logic link_clk_gate_out,        // link clocks enabled
    output logic sync_n_out,               // selected sync level
    output logic irq_out                   // level interrupt
);
    import link_regs_pkg::*;
    bank_state_t st_ff, nxt_st;
    logic realigned, multiframe_flag_a, sync_sel, clr_re, clr_al;
    logic addr_ok, wr_go;
    logic [7:0] status;

    // address phase capture; any word transfer is accepted
    assign addr_ok = hsel_in && hready_in &&
        (htrans_in == `HTRANS_NONSEQ || htrans_in == `HTRANS_SEQ);
    assign wr_go = st_ff.wr_pend;
    assign sync_sel = st_ff.ctrl_two[`BIT_SYNC_SEL];
    assign sync_n_out = sync_sel ? differential_sync_n_in : single_ended_sync_n_in;

    always_comb begin
        status = '0; // reserved bits read 0
        status[`BIT_LINK_UP] = data_encoding_state_in && st_ff.link_en;
        status[`BIT_SYNC_ST] = sync_n_out;
        status[`BIT_REALIGNED] = realigned;
        status[`BIT_MULTIFRAME_FLAG_A] = multiframe_flag_a;
        status[`BIT_PLL_LOCK] = pll_locked_in;
    end

    // write-1 clears only; zeros leave flags alone
    assign clr_re = wr_go && st_ff.idx == `IDX_STATUS && hwdata_in[`BIT_REALIGNED];
    assign clr_al = wr_go && st_ff.idx == `IDX_STATUS && hwdata_in[`BIT_MULTIFRAME_FLAG_A];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wr_pend = addr_ok && hwrite_in;
        nxt_st.rd_pend = addr_ok && !hwrite_in;
        if (addr_ok) begin
            nxt_st.idx = haddr_in[`IDX_HI:`IDX_LO];
        end
        if (wr_go) begin
            unique case (st_ff.idx)
                `IDX_CTRL_TWO: nxt_st.ctrl_two = hwdata_in[7:0] & `CTRL_TWO_MASK;
                `IDX_DEV_ID: nxt_st.dev_id = hwdata_in[7:0];
                `IDX_CTRL_THREE: nxt_st.ctrl_three = hwdata_in[7:0] & `CTRL_THREE_MASK;
                `IDX_IRQ_MASK: nxt_st.irq_mask = hwdata_in[7:0] & `FLAG_MASK;
                `IDX_LINK_EN: nxt_st.link_en = hwdata_in[`BIT_LINK_EN];
                default: ; // status bits read-only, unmapped ignored
            endcase
        end
        nxt_st.rdata = '0;
        if (addr_ok && !hwrite_in) begin
            unique case (haddr_in[`IDX_HI:`IDX_LO])
                `IDX_CTRL_TWO: nxt_st.rdata = {24'h000000, st_ff.ctrl_two};
                `IDX_DEV_ID: nxt_st.rdata = {24'h000000, st_ff.dev_id};
                `IDX_CTRL_THREE: nxt_st.rdata = {24'h000000, st_ff.ctrl_three};
                `IDX_STATUS: nxt_st.rdata = {24'h000000, status};
                `IDX_IRQ_MASK: nxt_st.rdata = {24'h000000, st_ff.irq_mask};
                `IDX_LINK_EN: nxt_st.rdata = {31'h00000000, st_ff.link_en};
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    align_flags u_flags (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .link_en_in(st_ff.link_en),
        .sysref_event_in(sysref_event_in),
        .phase_shift_in(phase_shift_in),
        .clr_realigned_in(clr_re),
        .clr_multiframe_flag_a_in(clr_al),
        .realigned_out(realigned),
        .multiframe_flag_a_out(multiframe_flag_a)
    );

    lane_pattern_ctrl u_pat (
        .pattern_in(st_ff.ctrl_two[`PAT_HI:0]),
        .end_char_code_in(st_ff.ctrl_three[`FRAME_END_CHAR_SELECT_HI:0]),
        .link_en_in(st_ff.link_en),
        .pattern_out(link_test_pattern_select_out),
        .end_char_out(frame_end_char_out),
        .lanes_static_out(lanes_static_out),
        .lanes_level_out(lanes_level_out)
    );

    assign hrdata_out = st_ff.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign pll_five_fourths_enable_out = st_ff.ctrl_two[`BIT_FIVE_FOURTHS];
    assign link_device_identifier_out = st_ff.dev_id;
    // comma only where the replacement conditions allow, never forced per frame
    assign insert_frame_end_out = frame_end_ok_in && st_ff.link_en;
    assign link_reset_out = !st_ff.link_en;
    assign serializer_pd_out = !st_ff.link_en;
    assign link_clk_gate_out = st_ff.link_en;
    assign irq_out = |(status & st_ff.irq_mask);

    property p_flag_w0;
        @(posedge clk_in) disable iff (reset_in)
        (wr_go && st_ff.idx == `IDX_STATUS && !hwdata_in[`BIT_MULTIFRAME_FLAG_A] && multiframe_flag_a)
            |=> multiframe_flag_a;
    endproperty
    a_flag_w0: assert property (p_flag_w0) else $error("write 0 cleared flag");
    property p_flag_w1;
        @(posedge clk_in) disable iff (reset_in)
        (clr_al && !(sysref_event_in)) |=> !multiframe_flag_a;
    endproperty
    a_flag_w1: assert property (p_flag_w1) else $error("write 1 did not clear");
    property p_sync_live;
        @(posedge clk_in) disable iff (reset_in)
        status[`BIT_SYNC_ST] == (sync_sel ? differential_sync_n_in : single_ended_sync_n_in);
    endproperty
    a_sync_live: assert property (p_sync_live) else $error("sync status wrong");
    property p_link_up;
        @(posedge clk_in) disable iff (reset_in)
        status[`BIT_LINK_UP] == (data_encoding_state_in && st_ff.link_en);
    endproperty
    a_link_up: assert property (p_link_up) else $error("link up wrong");
    property p_pll;
        @(posedge clk_in) disable iff (reset_in)
        status[`BIT_PLL_LOCK] == pll_locked_in;
    endproperty
    a_pll: assert property (p_pll) else $error("pll bit wrong");
    property p_five_fourths;
        @(posedge clk_in) disable iff (reset_in)
        (wr_go && st_ff.idx == `IDX_CTRL_TWO)
            |=> pll_five_fourths_enable_out == $past(hwdata_in[`BIT_FIVE_FOURTHS]);
    endproperty
    a_five_fourths: assert property (p_five_fourths) else $error("rate bit not written");
    property p_disabled;
        @(posedge clk_in) disable iff (reset_in)
        !st_ff.link_en |-> (link_reset_out && serializer_pd_out && !link_clk_gate_out);
    endproperty
    a_disabled: assert property (p_disabled) else $error("link not held");
    property p_static;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.link_en && st_ff.ctrl_two[`PAT_HI:0] == `PATTERN_HIGH)
            |-> (lanes_static_out && lanes_level_out);
    endproperty
    a_static: assert property (p_static) else $error("static high wrong");
    property p_reserved;
        @(posedge clk_in) disable iff (reset_in)
        (status & `STATUS_RSVD_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_static_low;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.link_en && st_ff.ctrl_two[`PAT_HI:0] == `PATTERN_LOW)
            |-> (lanes_static_out && !lanes_level_out);
    endproperty
    a_static_low: assert property (p_static_low) else $error("static low wrong");
    property p_pat_rsvd;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.ctrl_two[`PAT_HI:0] > `PATTERN_LAST_VALID)
            |-> (link_test_pattern_select_out == TP_NORMAL);
    endproperty
    a_pat_rsvd: assert property (p_pat_rsvd) else $error("reserved pattern used");
    property p_pat_pass;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.ctrl_two[`PAT_HI:0] <= `PATTERN_LAST_VALID)
            |-> (link_test_pattern_select_out == st_ff.ctrl_two[`PAT_HI:0]);
    endproperty
    a_pat_pass: assert property (p_pat_pass) else $error("pattern code lost");
    property p_dev_id;
        @(posedge clk_in) disable iff (reset_in)
        (wr_go && st_ff.idx == `IDX_DEV_ID)
            |=> link_device_identifier_out == $past(hwdata_in[7:0]);
    endproperty
    a_dev_id: assert property (p_dev_id) else $error("identifier not written");
    property p_sync_sel;
        @(posedge clk_in) disable iff (reset_in)
        (wr_go && st_ff.idx == `IDX_CTRL_TWO)
            |=> sync_sel == $past(hwdata_in[`BIT_SYNC_SEL]);
    endproperty
    a_sync_sel: assert property (p_sync_sel) else $error("sync select not written");
    property p_frame_ins;
        @(posedge clk_in) disable iff (reset_in)
        !(frame_end_ok_in && st_ff.link_en) |-> !insert_frame_end_out;
    endproperty
    a_frame_ins: assert property (p_frame_ins) else $error("comma forced");
    property p_char_k28_1;
        @(posedge clk_in) disable iff (reset_in)
        (st_ff.ctrl_three[`FRAME_END_CHAR_SELECT_HI:0] == 2'h1) |-> (frame_end_char_out == `KCODE_K28_1);
    endproperty
    a_char_k28_1: assert property (p_char_k28_1) else $error("frame char wrong");
    property p_realign_w0;
        @(posedge clk_in) disable iff (reset_in)
        (wr_go && st_ff.idx == `IDX_STATUS && !hwdata_in[`BIT_REALIGNED] && realigned)
            |=> realigned;
    endproperty
    a_realign_w0: assert property (p_realign_w0) else $error("write 0 cleared flag");
endmodule : link_regs
`default_nettype wire

// >>> dv/link_rx_model.sv
// Purpose: far-side receiver model driving both sync lines
// Assumes: receiver holds sync asserted until lanes have run a few cycles
// Notes: the differential line level is commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
    input wire logic clk_in,       // clock
    input wire logic reset_in,     // sync reset
    input wire logic link_on_in,   // lanes running
    input wire logic diff_lvl_in,  // commanded differential level
    output logic se_n_out,         // single-ended sync, low asserted
    output logic diff_n_out        // differential sync, low asserted
);
    logic [2:0] run_ff;
    // sync released only after four running cycles, like a real lock-up
    always_ff @(posedge clk_in) begin
        if (reset_in || !link_on_in) begin
            run_ff <= 3'h0;
        end else if (run_ff != 3'h4) begin
            run_ff <= run_ff + 3'h1;
        end
    end
    assign se_n_out = (run_ff == 3'h4);
    assign diff_n_out = diff_lvl_in;
endmodule : link_rx_model
`default_nettype wire

// >>> dv/test_jesd_link_control_status_regs.sv
// Purpose: self-checking bench for the link register bank
// Assumes: slave answers without wait states, byte address is four times index
// Notes: control writes are made with the link disabled
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defines.svh"
module test_jesd_link_control_status_regs;
    logic clk_in, reset_in, hsel, hwrite, sysref, phase, fe_ok, enc_state, pll, diff_lvl;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, fivefourths, fe_ins, l_st, l_lv, l_rst, l_pd, l_gate, sync_n, irq;
    logic se_n, diff_n;
    logic [3:0] pat;
    logic [7:0] did, fch, v;
    logic [7:0] fc_tab [4] = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
    int error_cnt = 0;
    int checks = 0;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
    link_regs dut_u (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hreadyout),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .single_ended_sync_n_in(se_n), .differential_sync_n_in(diff_n),
        .data_encoding_state_in(enc_state),
        .pll_locked_in(pll), .sysref_event_in(sysref), .phase_shift_in(phase),
        .frame_end_ok_in(fe_ok), .pll_five_fourths_enable_out(fivefourths),
        .link_test_pattern_select_out(pat), .link_device_identifier_out(did),
        .frame_end_char_out(fch), .insert_frame_end_out(fe_ins), .lanes_static_out(l_st),
        .lanes_level_out(l_lv), .link_reset_out(l_rst), .serializer_pd_out(l_pd),
        .link_clk_gate_out(l_gate), .sync_n_out(sync_n), .irq_out(irq));
    link_rx_model rx_u (.clk_in(clk_in), .reset_in(reset_in), .link_on_in(l_gate),
        .diff_lvl_in(diff_lvl), .se_n_out(se_n), .diff_n_out(diff_n));
    initial clk_in = 1'b0;
    always #25 clk_in = ~clk_in;
    task automatic ahb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'h0};
        htrans <= `HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk_in);
        while (hreadyout !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_in);
        while (hreadyout !== 1'b1) @(posedge clk_in);
        rdv = hrdata;
    endtask : ahb
    // extra edge so the stored value has landed before outputs are looked at
    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        ahb(1'b1, idx, wd);
        @(posedge clk_in);
    endtask : wr
    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        `CHK(rdv, exp)
    endtask : rd_chk
    task automatic ev(input logic s, input logic p);
        sysref <= s;
        phase <= p;
        @(posedge clk_in);
        sysref <= 1'b0;
        phase <= 1'b0;
        @(posedge clk_in);
    endtask : ev
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    initial begin
        {hsel, hwrite, sysref, phase, fe_ok, enc_state, pll} = 7'h0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = `HSIZE_WORD;
        diff_lvl = 1'b1;
        reset_in = 1'b1;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        rd_chk(`IDX_CTRL_TWO, 32'h0);
        rd_chk(`IDX_DEV_ID, 32'h0);
        rd_chk(`IDX_CTRL_THREE, 32'h0);
        rd_chk(`IDX_STATUS, 32'h0);
        `CHK({l_rst, l_pd, l_gate, irq}, 4'hC)
        $display("test reset values done");
        for (int c = 0; c < 16; c++) begin
            v = {c[0], c[1], 2'h3, c[3:0]};
            wr(`IDX_CTRL_TWO, {24'h0, v});
            rd_chk(`IDX_CTRL_TWO, {24'h0, v & `CTRL_TWO_MASK});
            `CHK(fivefourths, v[7])
            `CHK(pat, (c < 12) ? c[3:0] : 4'h0)
            `CHK(sync_n, v[6])
            rd_chk(`IDX_STATUS, {26'h0, v[6], 5'h0});
        end
        $display("test control two done");
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_CTRL_THREE, 32'hFC | c);
            rd_chk(`IDX_CTRL_THREE, c);
            `CHK(fch, fc_tab[c])
        end
        wr(`IDX_DEV_ID, 32'hA5);
        rd_chk(`IDX_DEV_ID, 32'hA5);
        `CHK(did, 8'hA5)
        $display("test frame char and identifier done");
        fe_ok <= 1'b1;
        for (int lv = 0; lv < 2; lv++) begin
            wr(`IDX_CTRL_TWO, 32'hA + lv);
            `CHK(fe_ins, 1'b0)
            wr(`IDX_LINK_EN, 32'h1);
            `CHK({l_rst, l_pd, l_gate}, 3'h1)
            `CHK({l_st, l_lv}, {1'b1, lv[0]})
            `CHK(fe_ins, 1'b1)
            wr(`IDX_LINK_EN, 32'h0);
        end
        $display("test link enable done");
        wr(`IDX_CTRL_TWO, 32'h0);
        wr(`IDX_LINK_EN, 32'h1);
        enc_state <= 1'b1;
        pll <= 1'b1;
        ev(1'b1, 1'b0);
        repeat (4) @(posedge clk_in);
        rd_chk(`IDX_STATUS, 32'h6C);
        ev(1'b0, 1'b1);
        rd_chk(`IDX_STATUS, 32'h7C);
        `CHK(irq, 1'b0)
        wr(`IDX_IRQ_MASK, 32'h18);
        rd_chk(`IDX_IRQ_MASK, 32'h18);
        `CHK(irq, 1'b1)
        wr(`IDX_STATUS, 32'hE7);
        rd_chk(`IDX_STATUS, 32'h7C);
        wr(`IDX_STATUS, 32'h08);
        rd_chk(`IDX_STATUS, 32'h74);
        `CHK(irq, 1'b1)
        ev(1'b1, 1'b0);
        rd_chk(`IDX_STATUS, 32'h74);
        wr(`IDX_STATUS, 32'h10);
        rd_chk(`IDX_STATUS, 32'h64);
        `CHK(irq, 1'b0)
        wr(`IDX_IRQ_MASK, 32'h0);
        ev(1'b0, 1'b1);
        `CHK(irq, 1'b0)
        enc_state <= 1'b0;
        pll <= 1'b0;
        @(posedge clk_in);
        rd_chk(`IDX_STATUS, 32'h30);
        $display("test status and interrupt done");
        wr(12'h300, 32'hFF);
        rd_chk(12'h300, 32'h0);
        `CHK(hresp, 1'b0)
        $display("test unmapped done");
        close_out();
    end
    // whole run is a few hundred cycles; this leaves ample margin
    initial begin
        repeat (3000) @(posedge clk_in);
        error_cnt++;
        close_out();
    end
endmodule : test_jesd_link_control_status_regs
`default_nettype wire
